// *** hw/tso_serial_out.sv ***
`timescale 1ns/10ps
`default_nettype none
module tso_serial_out
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [19:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        mux_wr,
  input  wire logic [3:0]  mux_chan,
  input  wire logic [15:0] chan_mux_word,
  input  wire logic        ext_bit_clock_pin,
  input  wire logic        ext_frame_sync_pin,
  output logic             serial_data_out_pin_o,
  output logic             serial_data_out_pin_oe_n,
  output logic             frame_irq,
  output logic             collision_error_irq
);
  typedef struct packed
  {
    logic [15:0][7:0]  start;
    logic [31:0]       slen;
    logic [15:0]       valid;
    logic [1:0]        frame_size_sel;
    logic              rate_override;
    logic              frame_or_simple_sel;
    logic              word_size_sel;
    logic              fsync_invert;
    logic              data_pin_enable;
    logic              data_pin_open_drain;
    logic              bitclk_invert;
    logic              section_enable;
    logic [1:0]        frame_irq_rate;
    logic              section_reset;
    tso_pkg::tso_state_e state;
    logic              obc_prev;
    logic              fs_prev;
    logic [8:0]        pos;
    logic              done_seen;
    logic [15:0][15:0] mux;
    logic [15:0]       fresh;
    logic [15:0][15:0] sreg;
    logic              coll;
    logic              irq;
    logic              dout;
    logic              doe_n;
    logic [15:0]       rdata;
    logic              rvalid;
  } tso_state_s;

  tso_state_s st_r;
  tso_state_s st_nxt;

  logic [1:0] pins_s;
  logic       int_bit_clock;
  logic       ofs;
  logic       bc_rise;
  logic       fs_rise;
  logic       frame_done;
  logic       sect_clr;
  logic [3:0] fcount;
  logic       irq_hit;
  logic       simple;
  logic [8:0] bits_cur;
  logic [8:0] span;
  logic [8:0] base;
  logic       hit_any;
  logic       hit_bit;
  logic       load;
  logic       coll_set;
  logic [15:0] word;
  logic [2:0] sel;
  int         ch;

  localparam int CTL_FRMSZ_LSB = tso_pkg::CTL_FRMSZ_LSB;
  localparam int CTL_IRQ_LSB   = tso_pkg::CTL_IRQ_LSB;

  tso_sync2
  #(
    .W (2)
  )
  u_sync
  (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({ext_frame_sync_pin, ext_bit_clock_pin}),
    .sync_out (pins_s)
  );

  tso_frame_ctr u_fctr
  (
    .clock   (clock),
    .rstn    (rstn),
    .clr     (sect_clr),
    .tick    (frame_done),
    .rate    (st_r.frame_irq_rate),
    .count   (fcount),
    .irq_hit (irq_hit)
  );

  assign int_bit_clock      = pins_s[0] ^ st_r.bitclk_invert;
  assign ofs      = pins_s[1] ^ st_r.fsync_invert;
  assign simple   = st_r.frame_or_simple_sel;
  assign sect_clr = st_r.section_reset || !st_r.section_enable;
  assign bc_rise  = int_bit_clock && !st_r.obc_prev && (st_r.state != tso_pkg::ST_IDLE);
  // Sync is sampled on bit-clock edges only, so glitches between edges are ignored
  assign fs_rise  = bc_rise && ofs && !st_r.fs_prev;
  assign span     = simple ? (st_r.word_size_sel ? tso_pkg::WORD_BITS_8
                                                 : tso_pkg::WORD_BITS_16)
                           : tso_pkg::frame_len(st_r.frame_size_sel);
  assign frame_done = bc_rise && (st_r.state == tso_pkg::ST_RUN) && !fs_rise
                      && !st_r.done_seen && (st_r.pos == span - 9'h001) && !simple;

  always_comb
  begin
    st_nxt   = st_r;
    hit_any  = 1'b0;
    hit_bit  = 1'b0;
    coll_set = 1'b0;
    load     = 1'b0;
    word     = 16'h0000;
    bits_cur = 9'h000;
    base     = 9'h000;
    sel      = 3'h0;

    st_nxt.section_reset = 1'b0;
    st_nxt.obc_prev      = int_bit_clock;
    st_nxt.irq           = 1'b0;
    st_nxt.rvalid        = reg_rd;

    if (reg_rd)
    begin
      st_nxt.rdata = 16'h0000;
      if (reg_addr >= tso_pkg::ADDR_START_FIRST && reg_addr <= tso_pkg::ADDR_START_LAST)
      begin
        sel = reg_addr[2:0];
        st_nxt.rdata = {st_r.start[{sel, 1'b1}], st_r.start[{sel, 1'b0}]};
      end
      else
      begin
        unique case (reg_addr)
          tso_pkg::ADDR_SLEN_LO: st_nxt.rdata = st_r.slen[15:0];
          tso_pkg::ADDR_SLEN_HI: st_nxt.rdata = st_r.slen[31:16];
          tso_pkg::ADDR_VALID:   st_nxt.rdata = st_r.valid;
          tso_pkg::ADDR_CTRL:
          begin
            st_nxt.rdata[CTL_FRMSZ_LSB +: 2] = st_r.frame_size_sel;
            st_nxt.rdata[tso_pkg::CTL_RATE_OVR] = st_r.rate_override;
            st_nxt.rdata[tso_pkg::CTL_MODE]     = st_r.frame_or_simple_sel;
            st_nxt.rdata[tso_pkg::CTL_WSIZE]    = st_r.word_size_sel;
            st_nxt.rdata[tso_pkg::CTL_FS_INV]   = st_r.fsync_invert;
            st_nxt.rdata[tso_pkg::CTL_PIN_EN]   = st_r.data_pin_enable;
            st_nxt.rdata[tso_pkg::CTL_PIN_OD]   = st_r.data_pin_open_drain;
            st_nxt.rdata[tso_pkg::CTL_BC_INV]   = st_r.bitclk_invert;
            st_nxt.rdata[tso_pkg::CTL_ENABLE]   = st_r.section_enable;
            st_nxt.rdata[CTL_IRQ_LSB +: 2]      = st_r.frame_irq_rate;
          end
          default: st_nxt.rdata = 16'h0000;
        endcase
      end
    end

    if (reg_wr)
    begin
      if (reg_addr >= tso_pkg::ADDR_START_FIRST && reg_addr <= tso_pkg::ADDR_START_LAST)
      begin
        sel = reg_addr[2:0];
        st_nxt.start[{sel, 1'b0}] = reg_wdata[7:0];
        st_nxt.start[{sel, 1'b1}] = reg_wdata[15:8];
      end
      else
      begin
        unique case (reg_addr)
          tso_pkg::ADDR_SLEN_LO: st_nxt.slen[15:0]  = reg_wdata;
          tso_pkg::ADDR_SLEN_HI: st_nxt.slen[31:16] = reg_wdata;
          tso_pkg::ADDR_VALID:   st_nxt.valid       = reg_wdata;
          tso_pkg::ADDR_CTRL:
          begin
            st_nxt.frame_size_sel      = reg_wdata[CTL_FRMSZ_LSB +: 2];
            st_nxt.rate_override       = reg_wdata[tso_pkg::CTL_RATE_OVR];
            st_nxt.frame_or_simple_sel = reg_wdata[tso_pkg::CTL_MODE];
            st_nxt.word_size_sel       = reg_wdata[tso_pkg::CTL_WSIZE];
            st_nxt.fsync_invert        = reg_wdata[tso_pkg::CTL_FS_INV];
            st_nxt.data_pin_enable     = reg_wdata[tso_pkg::CTL_PIN_EN];
            st_nxt.data_pin_open_drain = reg_wdata[tso_pkg::CTL_PIN_OD];
            st_nxt.bitclk_invert       = reg_wdata[tso_pkg::CTL_BC_INV];
            st_nxt.section_enable      = reg_wdata[tso_pkg::CTL_ENABLE];
            st_nxt.frame_irq_rate      = reg_wdata[CTL_IRQ_LSB +: 2];
            st_nxt.section_reset       = reg_wdata[tso_pkg::CTL_SRESET];
          end
          default: st_nxt.rdata = st_nxt.rdata;
        endcase
      end
    end

    if (mux_wr)
    begin
      st_nxt.mux[mux_chan] = chan_mux_word;
    end

    if (bc_rise)
    begin
      st_nxt.fs_prev = ofs;
      if (fs_rise)
      begin
        st_nxt.pos       = 9'h000;
        st_nxt.done_seen = 1'b0;
        st_nxt.state     = tso_pkg::ST_RUN;
      end
      else if (st_r.pos != 9'h1FF)
      begin
        st_nxt.pos = st_r.pos + 9'h001;
      end
      if (frame_done)
        st_nxt.done_seen = 1'b1;
    end

    // Loads happen at frame start; then the channel on this bit shifts
    for (ch = 0; ch < 16; ch++)
    begin
      word = st_r.sreg[ch];
      if (fs_rise && st_r.valid[ch])
      begin
        if (simple)
          load = (ch == 0);
        else if (st_r.rate_override)
          load = (fcount & tso_pkg::irq_mask(st_r.frame_irq_rate)) == 4'h0;
        else
          load = (fcount & tso_pkg::reload_mask(st_r.slen[2*ch +: 2])) == 4'h0;
        if (load)
        begin
          word = (simple && st_r.word_size_sel) ? {st_r.mux[ch][7:0], 8'h00}
                                                : st_r.mux[ch];
          st_nxt.fresh[ch] = 1'b0;
          // Underrun: reloading a word nobody refreshed since the last load
          if (!simple && !st_r.fresh[ch])
            coll_set = 1'b1;
        end
      end
      if (mux_wr && mux_chan == ch[3:0])
        st_nxt.fresh[ch] = 1'b1;
      bits_cur = simple ? span : tso_pkg::sample_bits(st_r.slen[2*ch +: 2]);
      base     = simple ? 9'h000 : {1'b0, st_r.start[ch]};
      // Parked position would wrap to slot 0 before the first sync
      if (bc_rise && !hit_any && st_r.valid[ch] && (!simple || ch == 0)
          && (fs_rise || st_r.pos != 9'h1FF)
          && (fs_rise ? 9'h000 : st_r.pos + 9'h001) >= base
          && (fs_rise ? 9'h000 : st_r.pos + 9'h001) < base + bits_cur)
      begin
        hit_any = 1'b1;
        hit_bit = word[15];
        word    = {word[14:0], 1'b0};
      end
      st_nxt.sreg[ch] = word;
    end

    if (bc_rise)
    begin
      st_nxt.dout  = hit_bit;
      // Idle slots release the line for other talkers on the bus
      st_nxt.doe_n = !(hit_any && st_r.data_pin_enable)
                     || (st_r.data_pin_open_drain && hit_bit);
    end
    if (!st_r.data_pin_enable)
      st_nxt.doe_n = 1'b1;
    if (st_nxt.data_pin_open_drain)
      st_nxt.dout = 1'b0;

    if (irq_hit && !simple)
      st_nxt.irq = 1'b1;

    // Fresh error wins over a clear arriving in the same cycle
    st_nxt.coll = (st_r.coll && !(reg_wr && reg_addr == tso_pkg::ADDR_CTRL
                                  && reg_wdata[tso_pkg::CTL_COLL_CLR] && !simple))
                  || coll_set;

    if (sect_clr)
    begin
      st_nxt.state     = st_nxt.section_enable ? tso_pkg::ST_WAIT : tso_pkg::ST_IDLE;
      st_nxt.pos       = 9'h1FF;
      st_nxt.done_seen = 1'b1;
      st_nxt.fs_prev   = 1'b1;
      st_nxt.sreg      = '0;
      st_nxt.fresh     = '0;
      st_nxt.irq       = 1'b0;
      st_nxt.doe_n     = 1'b1;
      st_nxt.dout      = 1'b0;
      if (st_r.section_reset)
        st_nxt.coll = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r                     <= '0;
      st_r.start               <= {8{tso_pkg::START_RESET}};
      st_r.slen                <= {2{tso_pkg::SLEN_RESET}};
      st_r.valid               <= tso_pkg::VALID_RESET;
      st_r.frame_size_sel      <= tso_pkg::CTRL_RESET[CTL_FRMSZ_LSB +: 2];
      st_r.frame_irq_rate      <= tso_pkg::CTRL_RESET[CTL_IRQ_LSB +: 2];
      st_r.state               <= tso_pkg::ST_IDLE;
      st_r.pos                 <= 9'h1FF;
      st_r.done_seen           <= 1'b1;
      st_r.fs_prev             <= 1'b1;
      st_r.doe_n               <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata                = st_r.rdata;
  assign reg_rvalid               = st_r.rvalid;
  assign serial_data_out_pin_o    = st_r.dout;
  assign serial_data_out_pin_oe_n = st_r.doe_n;
  assign frame_irq                = st_r.irq;
  assign collision_error_irq      = st_r.coll;
endmodule
`default_nettype wire

// *** hw/tso_pkg.sv ***
package tso_pkg;
  localparam logic [19:0] ADDR_START_FIRST = 20'hE0030;
  localparam logic [19:0] ADDR_START_LAST  = 20'hE0037;
  localparam logic [19:0] ADDR_SLEN_LO     = 20'hE0038;
  localparam logic [19:0] ADDR_SLEN_HI     = 20'hE0039;
  localparam logic [19:0] ADDR_CTRL        = 20'hE003A;
  localparam logic [19:0] ADDR_VALID       = 20'hE003B;

  localparam int CTL_FRMSZ_LSB = 12;
  localparam int CTL_RATE_OVR  = 11;
  localparam int CTL_MODE      = 10;
  localparam int CTL_WSIZE     = 9;
  localparam int CTL_FS_INV    = 8;
  localparam int CTL_COLL_CLR  = 7;
  localparam int CTL_PIN_EN    = 6;
  localparam int CTL_PIN_OD    = 5;
  localparam int CTL_SRESET    = 4;
  localparam int CTL_BC_INV    = 3;
  localparam int CTL_ENABLE    = 2;
  localparam int CTL_IRQ_LSB   = 0;

  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [15:0] SLEN_RESET  = 16'h0000;
  localparam logic [15:0] VALID_RESET = 16'h0000;

  localparam logic [8:0] FRAME_BITS_256 = 9'h100;
  localparam logic [8:0] FRAME_BITS_192 = 9'h0C0;
  localparam logic [8:0] FRAME_BITS_128 = 9'h080;
  localparam logic [8:0] FRAME_BITS_64  = 9'h040;
  localparam logic [8:0] WORD_BITS_16   = 9'h010;
  localparam logic [8:0] WORD_BITS_8    = 9'h008;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b11
  } tso_state_e;

  function automatic logic [8:0] frame_len(input logic [1:0] code);
    unique case (code)
      2'b00: frame_len = FRAME_BITS_256;
      2'b01: frame_len = FRAME_BITS_192;
      2'b10: frame_len = FRAME_BITS_128;
      2'b11: frame_len = FRAME_BITS_64;
    endcase
  endfunction

  function automatic logic [8:0] sample_bits(input logic [1:0] code);
    sample_bits = 9'h001 << code;
  endfunction

  // Frames between parallel loads, minus one: 16, 8, 4, 2 frames
  function automatic logic [3:0] reload_mask(input logic [1:0] code);
    reload_mask = 4'hF >> code;
  endfunction

  // Frames between interrupts, minus one: 2, 4, 8, 16 frames
  function automatic logic [3:0] irq_mask(input logic [1:0] code);
    irq_mask = 4'hF >> (2'h3 - code);
  endfunction
endpackage

// *** hw/tso_sync2.sv ***
`timescale 1ns/10ps
`default_nettype none
module tso_sync2
#(
  parameter int W = 2
)
(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } tso_sync_s;

  tso_sync_s st_r;
  tso_sync_s st_nxt;

  always_comb
  begin
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.stable;
endmodule
`default_nettype wire

// *** hw/tso_frame_ctr.sv ***
`timescale 1ns/10ps
`default_nettype none
module tso_frame_ctr
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [1:0] rate,
  output logic      [3:0] count,
  output logic            irq_hit
);
  typedef struct packed
  {
    logic [3:0] cnt;
  } tso_fctr_s;

  tso_fctr_s st_r;
  tso_fctr_s st_nxt;
  logic [3:0] inc;

  always_comb
  begin
    inc        = st_r.cnt + 4'h1;
    st_nxt.cnt = st_r.cnt;
    if (clr)
      st_nxt.cnt = 4'h0;
    else if (tick)
      st_nxt.cnt = inc;
    // Shared count: low bits wrapping mark both reload and interrupt points
    irq_hit = tick && !clr && ((inc & tso_pkg::irq_mask(rate)) == 4'h0);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign count = st_r.cnt;
endmodule
`default_nettype wire

// *** testbench/tso_serial_out_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module tso_serial_out_checker
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [19:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        serial_data_out_pin_o,
  input wire logic        serial_data_out_pin_oe_n,
  input wire logic        frame_irq,
  input wire logic        collision_error_irq
);
  logic [15:0] ctl_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Mirror of the control word; three quiet cycles absorb the output register lag
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      ctl_r <= 16'h0000;
    else if (reg_wr && reg_addr == tso_pkg::ADDR_CTRL)
      ctl_r <= reg_wdata;

  sequence ctrl_wr;
    reg_wr && reg_addr == tso_pkg::ADDR_CTRL;
  endsequence

  sequence ctrl_rd;
    reg_rd && reg_addr == tso_pkg::ADDR_CTRL;
  endsequence

  reset_idle_a: assert property ($rose(rstn) |-> serial_data_out_pin_oe_n && !frame_irq
    && !collision_error_irq && !reg_rvalid) else $error("outputs busy after reset");
  read_latency_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer timing");
  ctrl_reads_a: assert property (ctrl_rd |=> !reg_rdata[4] && !reg_rdata[7])
    else $error("self-clearing bit read back");
  pin_off_a: assert property ((!ctl_r[6]) [*3] |-> serial_data_out_pin_oe_n)
    else $error("pin driven while disabled");
  idle_section_a: assert property ((!ctl_r[2]) [*3] |-> serial_data_out_pin_oe_n && !frame_irq)
    else $error("activity while section off");
  open_drain_a: assert property (ctl_r[5] [*3] |-> !serial_data_out_pin_o)
    else $error("open drain drives high");
  simple_no_irq_a: assert property (ctl_r[10] [*3] |-> !frame_irq)
    else $error("frame interrupt in simple mode");
  irq_pulse_a: assert property (frame_irq |=> !frame_irq)
    else $error("frame interrupt too long");
  coll_clear_a: assert property (ctrl_wr ##0 (reg_wdata[7] && !reg_wdata[10]) |->
    ##[1:2] !collision_error_irq) else $error("collision not cleared");
  coll_keep_a: assert property (collision_error_irq ##0 ctrl_wr ##0
    (!reg_wdata[7] && !reg_wdata[4]) |=> collision_error_irq) else $error("collision lost");
  sect_reset_a: assert property (ctrl_wr ##0 reg_wdata[4] |->
    ##2 (!collision_error_irq && !frame_irq)) else $error("section reset ineffective");
endmodule
`default_nettype wire

// *** testbench/tso_line_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tso_line_model
(
  input  wire logic inv_bc,
  input  wire logic inv_fs,
  input  wire logic data_o,
  input  wire logic data_oe_n,
  output logic      bit_clk_pin,
  output logic      fsync_pin
);
  logic      bc = 1'b0;
  logic      fs = 1'b0;
  logic      lvl [0:255];
  logic      drv [0:255];
  // Pull-up on the shared data line
  wire logic pin_level = data_oe_n ? 1'b1 : data_o;

  assign bit_clk_pin = bc ^ inv_bc;
  assign fsync_pin   = fs ^ inv_fs;

  // Clock stands still between frames; a spare slot flushes the last bit.
  // A leading quiet slot lets the block see the sync as a fresh rise.
  // Sampling just before the next rise keeps clear of the pin's 2-3 clock lag.
  task automatic run_frame(input int nb);
    for (int i = -1; i <= nb; i++)
    begin
      fs = (i == 0);
      #100;
      if (i > 0)
      begin
        lvl[i-1] = pin_level;
        drv[i-1] = !data_oe_n;
      end
      bc = 1'b1;
      #100;
      bc = 1'b0;
    end
    fs = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/tso_serial_out_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module tso_serial_out_bench;
  typedef struct packed
  {
    logic [15:0] ctrl;
    logic [15:0] valid;
    logic [7:0]  start;
    logic [1:0]  slen;
    logic [15:0] word;
    logic [4:0]  n;
    logic [15:0] expv;
  } tso_row_s;

  localparam int DLY = 2;
  logic        clock;
  logic        rstn      = 1'b0;
  logic [19:0] reg_addr  = 20'h00000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        mux_wr    = 1'b0;
  logic [15:0] mux_word  = 16'h0000;
  logic [3:0]  mux_ch    = 4'h0;
  logic        inv_bc    = 1'b0;
  logic        inv_fs    = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        bc_pin;
  logic        fs_pin;
  logic        dat_o;
  logic        dat_oe_n;
  logic        frame_irq;
  logic        coll_irq;
  logic        inwin;
  logic        b;
  tso_row_s    r;
  int          errors    = 0;
  int          cmp_count = 0;
  int          irq_cnt   = 0;
  int          nb;
  int          idx;
  int          base;
  tso_row_s    rows [9] = '{
    '{16'h0444, 16'h0001, 8'h00, 2'h0, 16'hA5C3, 5'h10, 16'hA5C3},
    '{16'h0644, 16'h0001, 8'h00, 2'h0, 16'h12B7, 5'h08, 16'h00B7},
    '{16'h054C, 16'h0001, 8'h00, 2'h0, 16'h6E19, 5'h10, 16'h6E19},
    '{16'h0464, 16'h0001, 8'h00, 2'h0, 16'h0F35, 5'h10, 16'h0F35},
    '{16'h3044, 16'h0001, 8'h05, 2'h3, 16'hC3F0, 5'h08, 16'h00C3},
    '{16'h3044, 16'h0001, 8'h3E, 2'h1, 16'hBFFF, 5'h02, 16'h0002},
    '{16'h3044, 16'h0000, 8'h05, 2'h3, 16'hC3F0, 5'h00, 16'h0000},
    '{16'h0404, 16'h0001, 8'h00, 2'h0, 16'hA5C3, 5'h00, 16'h0000},
    '{16'h0440, 16'h0001, 8'h00, 2'h0, 16'hA5C3, 5'h00, 16'h0000}};

  tso_serial_out i_tso_serial_out
  (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mux_wr(mux_wr), .mux_chan(mux_ch), .chan_mux_word(mux_word),
    .ext_bit_clock_pin(bc_pin), .ext_frame_sync_pin(fs_pin),
    .serial_data_out_pin_o(dat_o), .serial_data_out_pin_oe_n(dat_oe_n),
    .frame_irq(frame_irq), .collision_error_irq(coll_irq)
  );

  tso_line_model i_tso_line_model
  (
    .inv_bc(inv_bc), .inv_fs(inv_fs), .data_o(dat_o), .data_oe_n(dat_oe_n),
    .bit_clk_pin(bc_pin), .fsync_pin(fs_pin)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
    if (frame_irq === 1'b1)
      irq_cnt++;

  task automatic chk(input logic [15:0] got, input logic [15:0] expv);
    cmp_count++;
    if (got !== expv)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, expv);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge clock);
    #DLY;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #DLY;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [15:0] expv);
    @(posedge clock);
    #DLY;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #DLY;
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, expv);
  endtask

  task automatic mux(input logic [15:0] w);
    @(posedge clock);
    #DLY;
    mux_word = w;
    mux_wr = 1'b1;
    @(posedge clock);
    #DLY;
    mux_wr = 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #DLY;
  endtask

  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clock);
    #DLY;
    rstn = 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      wr(tso_pkg::ADDR_CTRL, 16'h0010);
      inv_bc = r.ctrl[3];
      inv_fs = r.ctrl[8];
      wr(tso_pkg::ADDR_START_FIRST, {8'h00, r.start});
      wr(tso_pkg::ADDR_SLEN_LO, {14'h0000, r.slen});
      wr(tso_pkg::ADDR_VALID, r.valid);
      mux(r.word);
      wr(tso_pkg::ADDR_CTRL, r.ctrl);
      nb = r.ctrl[10] ? 20 : 64;
      i_tso_line_model.run_frame(nb);
      for (int k = 0; k < nb; k++)
      begin
        inwin = k >= r.start && k < r.start + r.n;
        idx = r.n - 1 - k + r.start;
        b = r.expv[idx[3:0]];
        chk({15'h0000, i_tso_line_model.drv[k]}, {15'h0000, inwin && !(r.ctrl[5] && b)});
        chk({15'h0000, i_tso_line_model.lvl[k]}, {15'h0000, !inwin || b});
      end
    end
    // Section reset and collision clear requested together
    wr(tso_pkg::ADDR_CTRL, 16'h3CFB);
    rd(tso_pkg::ADDR_CTRL, 16'h3C6B);
    wr(tso_pkg::ADDR_START_LAST, 16'hA55A);
    rd(tso_pkg::ADDR_START_LAST, 16'hA55A);
    wr(tso_pkg::ADDR_SLEN_HI, 16'hE41B);
    rd(tso_pkg::ADDR_SLEN_HI, 16'hE41B);
    wr(20'hE003C, 16'hFFFF);
    rd(20'hE003C, 16'h0000);
    rd(tso_pkg::ADDR_VALID, 16'h0001);
    rstn = 1'b0;
    settle();
    chk({13'h0000, frame_irq, coll_irq, dat_oe_n}, 16'h0001);
    rstn = 1'b1;
    rd(tso_pkg::ADDR_CTRL, tso_pkg::CTRL_RESET);
    rd(tso_pkg::ADDR_START_LAST, tso_pkg::START_RESET);
    rd(tso_pkg::ADDR_SLEN_HI, tso_pkg::SLEN_RESET);
    rd(tso_pkg::ADDR_VALID, tso_pkg::VALID_RESET);
    // One-bit sample reloads only every 16 frames unless overridden
    for (int ov = 0; ov < 2; ov++)
    begin
      wr(tso_pkg::ADDR_CTRL, 16'h0010);
      wr(tso_pkg::ADDR_VALID, 16'h0001);
      wr(tso_pkg::ADDR_CTRL, 16'h3004 | 16'(ov << 11));
      // Words written while disabled are not fresh, so write after enabling
      mux(16'h5A3C);
      repeat (3) i_tso_line_model.run_frame(64);
      chk({15'h0000, coll_irq}, 16'(ov));
      wr(tso_pkg::ADDR_CTRL, 16'h3004 | 16'(ov << 11));
      settle();
      chk({15'h0000, coll_irq}, 16'(ov));
      wr(tso_pkg::ADDR_CTRL, 16'h3084);
      settle();
      chk({15'h0000, coll_irq}, 16'h0000);
    end
    // Two channels at their own start positions
    wr(tso_pkg::ADDR_CTRL, 16'h0010);
    wr(tso_pkg::ADDR_START_FIRST, 16'h1400);
    wr(tso_pkg::ADDR_SLEN_LO, 16'h000F);
    wr(tso_pkg::ADDR_VALID, 16'h0003);
    wr(tso_pkg::ADDR_CTRL, 16'h3044);
    mux(16'hA500);
    mux_ch = 4'h1;
    mux(16'h3C00);
    mux_ch = 4'h0;
    i_tso_line_model.run_frame(64);
    for (int k = 0; k < 8; k++)
    begin
      chk({15'h0000, i_tso_line_model.lvl[k]}, {15'h0000, 1'(16'hA500 >> (15 - k))});
      chk({15'h0000, i_tso_line_model.lvl[k + 20]}, {15'h0000, 1'(16'h3C00 >> (15 - k))});
    end
    // Frame size code and interrupt rate code stepped together
    for (int c = 0; c < 4; c++)
    begin
      wr(tso_pkg::ADDR_CTRL, 16'h0010);
      base = irq_cnt;
      wr(tso_pkg::ADDR_CTRL, 16'(c * 16'h1001) | 16'h0004);
      repeat (4 << c) i_tso_line_model.run_frame(256 - 64 * c);
      settle();
      chk(16'(irq_cnt - base), 16'h0002);
    end
    conclude();
  end

  initial
  begin
    #2000000;
    errors++;
    conclude();
  end
endmodule

bind tso_serial_out tso_serial_out_checker i_tso_serial_out_checker
(
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .serial_data_out_pin_o(serial_data_out_pin_o),
  .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n),
  .frame_irq(frame_irq), .collision_error_irq(collision_error_irq)
);
`default_nettype wire
